// file: rtl/edge_sync.v
// two-stage synchroniser with registered previous sample and edge pulses
// assumes the input is sampled on sys_clk
`timescale 1ns/1ps
module edge_sync (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire pin,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg prev;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  // edges compare current and previous registered samples
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

// file: rtl/ext_irq_map.vh
// constants for the external interrupt and wake logic
// assumes a 10 MHz state clock; included by the design files
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH

// ----------------------------------------
// waveform protect control fields
// ----------------------------------------
`define WPC_WIDTH        2
`define WPC_LEVEL_BIT    0
`define WPC_FALLING_BIT  1
`define WPC_RESET        2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS    100
`define WAKE_MIN_NS      50
// least time rounds up, never below one cycle
`define WAKE_CYCLES_RAW  ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CYCLES      ((`WAKE_CYCLES_RAW < 1) ? 1 : `WAKE_CYCLES_RAW)
`define WAKE_CNT_W       4

// ----------------------------------------
// power modes (one-hot)
// ----------------------------------------
`define PM_NORMAL        3'h1
`define PM_IDLE          3'h2
`define PM_POWERDOWN     3'h4

`endif

// file: rtl/external_interrupt_wake_logic.v
// external interrupt, nonmaskable interrupt and power-mode wake logic
// assumes one 10 MHz state clock; cpu supplies mode requests and enables
//
// How it works
// - control bit selects edge-triggered or level-sampled external interrupt.
// - control bit selects rising/high or falling/low as active polarity.
// - powerdown exits when external input stays active at least 50 ns, enabled or not.
// - after that wake, service routine runs only if interrupt is enabled.
// - idle exits whenever any enabled interrupt request is pending.
// - each rising edge on the nmi input in normal mode raises a nonmaskable request.
// - nonmaskable request outranks every other request when selecting service.
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module external_interrupt_wake_logic (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  external_interrupt_pin,
  input  wire                  nmi_pin,
  input  wire [`WPC_WIDTH-1:0] waveform_protect_control,
  input  wire                  ext_irq_enable,
  input  wire                  other_irq_pending,
  input  wire                  idle_request,
  input  wire                  powerdown_request,
  input  wire                  ext_irq_ack,
  input  wire                  nmi_ack,
  output reg                   ext_irq_pending,
  output reg                   nmi_pending,
  output wire                  service_nmi,
  output wire                  service_ext,
  output wire                  service_other,
  output reg                   in_idle,
  output reg                   in_powerdown,
  output reg                   wake_event
);

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  wire ext_level;
  wire ext_rise;
  wire ext_fall;
  wire nmi_rise;

  edge_sync u_ext_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin     (external_interrupt_pin),
    .level   (ext_level),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // an nmi pulse shorter than a state time may be missed entirely
  edge_sync u_nmi_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin     (nmi_pin),
    .level   (),
    .rise    (nmi_rise),
    .fall    ()
  );

  // ----------------------------------------
  // external interrupt detection
  // ----------------------------------------
  // level mode re-arms each cycle the input stays active, so ack only sticks once it drops
  wire use_level   = waveform_protect_control[`WPC_LEVEL_BIT];
  wire use_falling = waveform_protect_control[`WPC_FALLING_BIT];
  wire ext_active  = use_falling ? ~ext_level : ext_level;
  wire ext_edge    = use_falling ? ext_fall : ext_rise;
  wire ext_event   = use_level ? ext_active : ext_edge;

  // ----------------------------------------
  // power mode state
  // ----------------------------------------
  // one-hot codes; a stray code falls into the default branch and recovers
  localparam [2:0] NORMAL    = `PM_NORMAL;
  localparam [2:0] IDLE      = `PM_IDLE;
  localparam [2:0] POWERDOWN = `PM_POWERDOWN;

  reg  [2:0]             mode;
  reg  [2:0]             next_mode;
  reg  [`WAKE_CNT_W-1:0] wake_cnt;
  reg  [`WAKE_CNT_W-1:0] next_wake_cnt;
  wire                   wake_long;
  wire                   idle_wake;
  wire                   in_pd_mode;
  wire                   in_normal_mode;

  assign in_pd_mode     = (mode == POWERDOWN);
  assign in_normal_mode = (mode == NORMAL);

  // ----------------------------------------
  // powerdown wake timer
  // ----------------------------------------
  // active level counted while in powerdown; the clock is assumed kept running here
  always @* begin
    next_wake_cnt = wake_cnt;
    if (!in_pd_mode || !ext_active)
      next_wake_cnt = {`WAKE_CNT_W{1'b0}};
    else if (!wake_long)
      next_wake_cnt = wake_cnt + {{(`WAKE_CNT_W-1){1'b0}}, 1'b1};
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_cnt <= {`WAKE_CNT_W{1'b0}};
    end else begin
      wake_cnt <= next_wake_cnt;
    end
  end

  // the count stops at the limit, so a long hold cannot wrap and lose the wake
  assign wake_long = (wake_cnt >= (`WAKE_CYCLES - 1)) && ext_active;

  // ----------------------------------------
  // mode sequencing
  // ----------------------------------------
  assign idle_wake = (ext_irq_pending & ext_irq_enable) | nmi_pending
                   | other_irq_pending;

  always @* begin
    next_mode = mode;
    case (mode)
      NORMAL: begin
        // powerdown wins when both are asked for in one cycle
        if (powerdown_request)
          next_mode = POWERDOWN;
        else if (idle_request)
          next_mode = IDLE;
      end
      IDLE: begin
        if (idle_wake)
          next_mode = NORMAL;
      end
      POWERDOWN: begin
        if (wake_long)
          next_mode = NORMAL;
      end
      default: next_mode = NORMAL;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mode <= NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------
  // mode flags and wake pulse
  // ----------------------------------------
  // flags follow next_mode so they change on the same edge as the state
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      in_idle      <= 1'b0;
      in_powerdown <= 1'b0;
      wake_event   <= 1'b0;
    end else begin
      in_idle      <= (next_mode == IDLE);
      in_powerdown <= (next_mode == POWERDOWN);
      wake_event   <= !in_normal_mode && (next_mode == NORMAL);
    end
  end

  // ----------------------------------------
  // external interrupt request
  // ----------------------------------------
  // the powerdown wake latches a request only when enabled, so a disabled
  // wake resumes at the next instruction instead of a service routine
  wire ext_set = in_pd_mode ? (wake_long & ext_irq_enable)
                            : ext_event;
  reg  next_ext_irq_pending;

  // set wins over acknowledge in the same cycle
  always @* begin
    next_ext_irq_pending = ext_irq_pending;
    if (ext_set)
      next_ext_irq_pending = 1'b1;
    else if (ext_irq_ack)
      next_ext_irq_pending = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_irq_pending <= 1'b0;
    end else begin
      ext_irq_pending <= next_ext_irq_pending;
    end
  end

  // ----------------------------------------
  // nonmaskable request
  // ----------------------------------------
  // edges seen outside normal mode are dropped, not held for later
  wire nmi_set = nmi_rise & in_normal_mode;
  reg  next_nmi_pending;

  always @* begin
    next_nmi_pending = nmi_pending;
    if (nmi_set)
      next_nmi_pending = 1'b1;
    else if (nmi_ack)
      next_nmi_pending = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      nmi_pending <= 1'b0;
    end else begin
      nmi_pending <= next_nmi_pending;
    end
  end

  // ----------------------------------------
  // service selection
  // ----------------------------------------
  // fixed priority: nmi, then the external input, then everything else
  assign service_nmi   = nmi_pending;
  assign service_ext   = ~nmi_pending & ext_irq_pending & ext_irq_enable;
  assign service_other = ~nmi_pending & ~service_ext & other_irq_pending;
endmodule

// file: tb/ext_wake_sva.sv
// checker for the external interrupt and wake logic
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module ext_wake_sva (
  input wire                  sys_clk,
  input wire                  rst_n,
  input wire                  external_interrupt_pin,
  input wire                  nmi_pin,
  input wire [`WPC_WIDTH-1:0] waveform_protect_control,
  input wire                  ext_irq_enable,
  input wire                  other_irq_pending,
  input wire                  idle_request,
  input wire                  powerdown_request,
  input wire                  ext_irq_ack,
  input wire                  nmi_ack,
  input wire                  ext_irq_pending,
  input wire                  nmi_pending,
  input wire                  service_nmi,
  input wire                  service_ext,
  input wire                  service_other,
  input wire                  in_idle,
  input wire                  in_powerdown,
  input wire                  wake_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [1:0] wpc = waveform_protect_control;
  wire act = external_interrupt_pin ^ wpc[1];
  wire norm = !in_idle && !in_powerdown && !idle_request && !powerdown_request;
  // raw pin edges; the synchroniser delay is covered by the delay ranges
  sequence nmi_rise; $rose(nmi_pin) && norm; endsequence
  sequence ext_rise; $rose(act) && $stable(wpc) && !wpc[0] && norm && ext_irq_enable;
  endsequence
  sequence pd_held; in_powerdown && act ##1 act; endsequence
  nmi_edge_a: assert property (nmi_rise |-> ##[1:5] nmi_pending)
    else $error("nmi edge not taken");
  nmi_first_a: assert property (nmi_pending
    |-> service_nmi && !service_ext && !service_other) else $error("nmi not first");
  ext_edge_a: assert property (ext_rise |-> ##[1:5] ext_irq_pending)
    else $error("ext edge not taken");
  ext_level_a: assert property ((wpc[0] && act && norm && ext_irq_enable)[*5]
    |-> ext_irq_pending) else $error("ext level not taken");
  idle_wake_a: assert property (in_idle && (other_irq_pending || nmi_pending)
    |-> ##[1:2] (wake_event && !in_idle)) else $error("idle not left");
  pd_stay_a: assert property ((in_powerdown && !act)[*4] |=> in_powerdown)
    else $error("powerdown left early");
  pd_wake_a: assert property (pd_held |-> ##[1:4] wake_event)
    else $error("powerdown not left");
  pd_isr_a: assert property ($fell(in_powerdown) && !$past(ext_irq_pending)
    |-> wake_event && ext_irq_pending == $past(ext_irq_enable)) else $error("wake isr");
  wake_pulse_a: assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
  ext_pick_a: assert property (ext_irq_pending && ext_irq_enable && !nmi_pending
    |-> service_ext && !service_other) else $error("ext not picked");
  other_pick_a: assert property (other_irq_pending && !nmi_pending && !ext_irq_pending
    |-> service_other && !service_nmi) else $error("other not picked");
endmodule

// file: tb/external_interrupt_wake_logic_test.sv
// self-checking bench for the external interrupt and wake logic
// assumes irq_source on the pins; the checker is bound below
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module external_interrupt_wake_logic_test;
  reg sys_clk = 0, rst_n = 0, ext_req = 0, nmi_req = 0, ext_irq_enable = 1, look = 0;
  reg other_irq_pending = 0, idle_request = 0, powerdown_request = 0;
  reg ext_irq_ack = 0, nmi_ack = 0;
  reg [`WPC_WIDTH-1:0] waveform_protect_control = `WPC_RESET;
  wire external_interrupt_pin, nmi_pin, ext_irq_pending, nmi_pending, service_nmi;
  wire service_ext, service_other, in_idle, in_powerdown, wake_event;
  integer err_count = 0, n_compared = 0, cycles = 0, m;
  reg [4:0] q[$];
  wire [4:0] seen = {nmi_pending, ext_irq_pending, in_idle, in_powerdown, service_nmi};
  irq_source src (
    .sys_clk                (sys_clk),
    .ext_req                (ext_req),
    .nmi_req                (nmi_req),
    .external_interrupt_pin (external_interrupt_pin),
    .nmi_pin                (nmi_pin)
  );
  external_interrupt_wake_logic uut (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .external_interrupt_pin   (external_interrupt_pin),
    .nmi_pin                  (nmi_pin),
    .waveform_protect_control (waveform_protect_control),
    .ext_irq_enable           (ext_irq_enable),
    .other_irq_pending        (other_irq_pending),
    .idle_request             (idle_request),
    .powerdown_request        (powerdown_request),
    .ext_irq_ack              (ext_irq_ack),
    .nmi_ack                  (nmi_ack),
    .ext_irq_pending          (ext_irq_pending),
    .nmi_pending              (nmi_pending),
    .service_nmi              (service_nmi),
    .service_ext              (service_ext),
    .service_other            (service_other),
    .in_idle                  (in_idle),
    .in_powerdown             (in_powerdown),
    .wake_event               (wake_event)
  );
  initial forever #50 sys_clk = ~sys_clk;
  task step(input integer n); repeat (n) @(posedge sys_clk); endtask
  task chk(input [4:0] x); begin q.push_back(x); look <= 1; step(1); look <= 0; end endtask
  task finish_test; begin
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  // outputs are settled at the falling edge
  always @(negedge sys_clk) if (look) begin
    n_compared = n_compared + 1;
    if (seen !== q[0]) begin
      $display("mismatch status exp %b got %b", q[0], seen);
      err_count = err_count + 1;
    end
    q.pop_front();
  end
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin err_count = err_count + 1; finish_test; end
  end
  initial begin
    void'($urandom(32'hdcc0755e));
    step(10);
    rst_n <= 1;
    step(3);
    for (m = 0; m < 4; m = m + 1) begin
      waveform_protect_control <= m[1:0]; ext_req <= m[1]; step(4);
      ext_req <= !m[1]; step(5 + $urandom % 3);
      ext_req <= m[1]; step(5);
      chk(5'b01000);
      ext_irq_ack <= 1; step(1); ext_irq_ack <= 0; step(1);
      chk(5'b00000);
    end
    waveform_protect_control <= 2'h0; step(4);
    ext_req <= 0; ext_irq_ack <= 1; step(5); ext_irq_ack <= 0;
    // wake from powerdown with the interrupt masked, then enabled
    for (m = 0; m < 2; m = m + 1) begin
      ext_irq_enable <= m[0]; powerdown_request <= 1; step(1); powerdown_request <= 0; step(2);
      chk(5'b00010);
      ext_req <= 1; step(2); ext_req <= 0; step(5);
      chk({1'b0, m[0], 3'b000});
      ext_irq_ack <= 1; step(1); ext_irq_ack <= 0;
    end
    idle_request <= 1; step(1); idle_request <= 0; step(1);
    chk(5'b00100);
    other_irq_pending <= 1; step(3);
    chk(5'b00000);
    nmi_req <= 1; step(2); nmi_req <= 0; step(5);
    chk(5'b10001);
    nmi_ack <= 1; other_irq_pending <= 0; step(1); nmi_ack <= 0; step(1);
    idle_request <= 1; step(1); idle_request <= 0; nmi_req <= 1; step(3); nmi_req <= 0; step(3);
    chk(5'b00100);
    finish_test;
  end
endmodule
bind external_interrupt_wake_logic ext_wake_sva chk_i (
  .sys_clk                  (sys_clk),
  .rst_n                    (rst_n),
  .external_interrupt_pin   (external_interrupt_pin),
  .nmi_pin                  (nmi_pin),
  .waveform_protect_control (waveform_protect_control),
  .ext_irq_enable           (ext_irq_enable),
  .other_irq_pending        (other_irq_pending),
  .idle_request             (idle_request),
  .powerdown_request        (powerdown_request),
  .ext_irq_ack              (ext_irq_ack),
  .nmi_ack                  (nmi_ack),
  .ext_irq_pending          (ext_irq_pending),
  .nmi_pending              (nmi_pending),
  .service_nmi              (service_nmi),
  .service_ext              (service_ext),
  .service_other            (service_other),
  .in_idle                  (in_idle),
  .in_powerdown             (in_powerdown),
  .wake_event               (wake_event)
);

// file: tb/irq_source.sv
// board-level interrupt sources driving the two pins
// assumes the bench asks for levels at the rising clock edge
`timescale 1ns/1ps
module irq_source (
  input  wire sys_clk,
  input  wire ext_req,
  input  wire nmi_req,
  output reg  external_interrupt_pin = 1'b0,
  output reg  nmi_pin = 1'b0
);
  // levels change only on a clock edge, so each stands a whole 100 ns cycle
  always @(posedge sys_clk) begin
    external_interrupt_pin <= ext_req;
    nmi_pin <= nmi_req;
  end
endmodule
